/* design/rcc_pkg.sv */
package rcc_pkg;

  // Register offsets of the bank
  localparam logic [7:0] CH4_HIGH_POWER_SETTING_ADDR = 8'h43;
  localparam logic [7:0] CH4_STARTUP_ORDER_ADDR = 8'h44;
  localparam logic [7:0] CH4_CHANNEL_CONFIG_ADDR = 8'h45;
  localparam logic [7:0] LINREG1_ACTIVE_SETTING_ADDR = 8'h50;
  localparam logic [7:0] LINREG1_LOW_POWER_SETTING_ADDR = 8'h51;
  localparam logic [7:0] LINREG1_HIBERNATE_SETTING_ADDR = 8'h52;
  localparam logic [7:0] LINREG1_HIGH_PERF_SETTING_ADDR = 8'h53;
  localparam logic [7:0] LINREG1_STARTUP_ORDER_ADDR = 8'h54;

  // Reset values; linear regulator codes are replaced by the strap pins
  localparam logic [7:0] CH4_HIGH_POWER_SETTING_RST = 8'hFD;
  localparam logic [7:0] CH4_STARTUP_ORDER_RST = 8'h1C;
  localparam logic [7:0] CH4_CHANNEL_CONFIG_RST = 8'hA0;
  localparam logic [7:0] LINREG1_STARTUP_ORDER_RST = 8'h09;
  localparam logic [3:0] LINREG1_ENABLE_RST = 4'hB;

  // Field positions shared by the mode registers
  localparam int unsigned MODE_ENABLE_BIT = 7;
  localparam int unsigned MODE_FORCED_BIT = 6;
  localparam logic [7:0] LINREG_MODE_WR_MASK = 8'hBF;

  // Power mode encoding, also the index of the matching linear mode register
  localparam logic [1:0] PMODE_ACTIVE = 2'h0;
  localparam logic [1:0] PMODE_LOW_POWER = 2'h1;
  localparam logic [1:0] PMODE_HIBERNATE = 2'h2;
  localparam logic [1:0] PMODE_HIGH_PERF = 2'h3;

  // Restart delay after a global short-circuit shutdown
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned RESTART_DELAY_MS = 100;
  localparam int unsigned RESTART_CYCLES = (CLK_HZ / 1000) * RESTART_DELAY_MS;
  localparam int unsigned RESTART_CNT_W = 22;

  // Strap settle: two synchroniser stages plus one
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  typedef struct packed {
    logic enable;
    logic forced_switching;
    logic [5:0] voltage_code;
  } rcc_mode_t;

  typedef struct packed {
    logic [1:0] soft_start_rate;
    logic [1:0] startup_step;
    logic step_participation;
    logic [2:0] delay;
  } rcc_seq_t;

  typedef struct packed {
    logic fault_irq_mask;
    logic hiccup_select;
    logic output_drain_enable;
    logic phase_shift;
    logic [1:0] voltage_slew_rate;
    logic register_enable;
    logic register_override_select;
  } rcc_cfg_t;

  typedef enum logic [0:0] {
    RCC_RUN,
    RCC_SHUTDOWN
  } rcc_fsm_t;

endpackage

/* design/rcc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module rcc_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // Two stages; only the second stage reads the first
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;

endmodule
`default_nettype wire

/* design/rcc_regs.sv */
// What this block does
// - High-performance register bit 7 enables the fourth buck in that mode; resets one
// - Mode bit 6 set gives forced switching, cleared gives automatic pulse skipping
// - High-performance voltage code is bits 5-0; reset code means 1.8 V
// - Sequencing fields: soft-start rate, startup step, delay before soft start
// - Participation cleared: no start at step, done and good flags ignored
// - Fault mask set keeps the channel fault off the interrupt line
// - Hiccup set: short retries soft start on this channel only, others run
// - Hiccup clear: short shuts all channels, restart sequence after 100 ms
// - Config bit 5 controls output discharge when the channel is off
// - Config bit 4 set switches 180 degrees out of phase, else in phase
// - Config bits 3-2 set the dynamic voltage scaling slew rate
// - Override select set: register enable forces channel on or off
// - Under override, switching mode still comes from the mode registers
// - Linear regulator voltage codes load their reset value from strap pins
// - Linear enable resets one in active, low, high modes; zero in hibernate
`timescale 1ns/1ps
`default_nettype none
module rcc_regs
  import rcc_pkg::*;
#(
  parameter int unsigned P_RESTART_CYCLES = RESTART_CYCLES
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Register port from the serial link engine
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Power mode and settings of the other fourth-buck mode registers
  input wire logic [1:0] i_power_mode,
  input wire rcc_mode_t i_ch4_lower_mode_setting,
  // Pins and analog status, asynchronous
  input wire logic [5:0] i_linreg1_vsel_pins,
  input wire logic i_ch4_fault_flag,
  input wire logic i_ch4_short,
  input wire logic i_ch4_soft_start_done,
  input wire logic i_ch4_power_good,
  input wire logic i_linreg1_soft_start_done,
  input wire logic i_linreg1_power_good,
  // Fourth buck controls
  output rcc_mode_t o_ch4_setting,
  output rcc_seq_t o_ch4_seq,
  output logic o_ch4_step_flags_ok,
  output logic o_ch4_output_drain,
  output logic o_ch4_phase_shift,
  output logic [1:0] o_ch4_voltage_slew_rate,
  output logic o_ch4_hiccup_retry,
  // Linear regulator controls
  output rcc_mode_t o_linreg1_setting,
  output rcc_seq_t o_linreg1_seq,
  output logic o_linreg1_step_flags_ok,
  // System wide
  output logic o_all_channels_off,
  output logic o_restart_sequence,
  output logic o_irq_out_n
);

  typedef struct packed {
    logic [7:0] ch4_hpm;
    logic [7:0] ch4_seq;
    logic [7:0] ch4_cfg;
    logic [3:0][7:0] lin_mode;
    logic [7:0] lin_seq;
    logic [7:0] rdata;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic short_prev;
    rcc_fsm_t fsm;
    logic [RESTART_CNT_W-1:0] timer;
    logic restart;
    logic retry;
    logic irq_n;
    rcc_mode_t ch4_out;
    rcc_mode_t lin_out;
    logic drain;
  } rcc_state_t;

  localparam logic [RESTART_CNT_W-1:0] RESTART_LOAD =
    RESTART_CNT_W'(P_RESTART_CYCLES - 1);

  rcc_state_t st_reg;
  rcc_state_t st_next;
  logic [11:0] async_bus;
  logic [11:0] sync_bus;
  logic [5:0] vsel_s;
  logic fault_s;
  logic short_s;
  logic ch4_ssd_s;
  logic ch4_pok_s;
  logic lin_ssd_s;
  logic lin_pok_s;
  logic short_rise;
  rcc_cfg_t cfg;
  rcc_seq_t ch4_seq_f;
  rcc_seq_t lin_seq_f;
  rcc_mode_t ch4_sel;

  // Reset constant for one linear mode register, code overwritten by straps
  function automatic logic [7:0] lin_rst(input logic en);
    lin_rst = {en, 7'h00};
  endfunction

  // Read decode used only by the registered read path
  function automatic logic [7:0] reg_read(input rcc_state_t s, input logic [7:0] a);
    unique case (a)
      CH4_HIGH_POWER_SETTING_ADDR: reg_read = s.ch4_hpm;
      CH4_STARTUP_ORDER_ADDR: reg_read = s.ch4_seq;
      CH4_CHANNEL_CONFIG_ADDR: reg_read = s.ch4_cfg;
      LINREG1_ACTIVE_SETTING_ADDR: reg_read = s.lin_mode[0];
      LINREG1_LOW_POWER_SETTING_ADDR: reg_read = s.lin_mode[1];
      LINREG1_HIBERNATE_SETTING_ADDR: reg_read = s.lin_mode[2];
      LINREG1_HIGH_PERF_SETTING_ADDR: reg_read = s.lin_mode[3];
      LINREG1_STARTUP_ORDER_ADDR: reg_read = s.lin_seq;
      default: reg_read = 8'h00;
    endcase
  endfunction

  // Analog flags and strap pins all cross into the core clock
  assign async_bus = {i_linreg1_vsel_pins, i_ch4_fault_flag, i_ch4_short,
                      i_ch4_soft_start_done, i_ch4_power_good,
                      i_linreg1_soft_start_done, i_linreg1_power_good};

  rcc_sync #(
    .WIDTH(12)
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_async(async_bus),
    .o_sync(sync_bus)
  );

  assign {vsel_s, fault_s, short_s, ch4_ssd_s, ch4_pok_s, lin_ssd_s, lin_pok_s} = sync_bus;

  // Field views of the stored registers
  assign cfg = rcc_cfg_t'(st_reg.ch4_cfg);
  assign ch4_seq_f = rcc_seq_t'(st_reg.ch4_seq);
  assign lin_seq_f = rcc_seq_t'(st_reg.lin_seq);
  assign short_rise = short_s & ~st_reg.short_prev;

  // Fourth buck mode source: own register only in high-performance mode
  always_comb begin
    if (i_power_mode == PMODE_HIGH_PERF) begin
      ch4_sel = rcc_mode_t'(st_reg.ch4_hpm);
    end else begin
      ch4_sel = i_ch4_lower_mode_setting;
    end
  end

  // Next state of the whole block
  always_comb begin
    st_next = st_reg;
    st_next.restart = 1'b0;
    st_next.retry = 1'b0;
    st_next.short_prev = short_s;
    // Host writes; linear reserved bit 6 never stored
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        CH4_HIGH_POWER_SETTING_ADDR: st_next.ch4_hpm = i_reg_wdata;
        CH4_STARTUP_ORDER_ADDR: st_next.ch4_seq = i_reg_wdata;
        CH4_CHANNEL_CONFIG_ADDR: st_next.ch4_cfg = i_reg_wdata;
        LINREG1_ACTIVE_SETTING_ADDR:
          st_next.lin_mode[0] = i_reg_wdata & LINREG_MODE_WR_MASK;
        LINREG1_LOW_POWER_SETTING_ADDR:
          st_next.lin_mode[1] = i_reg_wdata & LINREG_MODE_WR_MASK;
        LINREG1_HIBERNATE_SETTING_ADDR:
          st_next.lin_mode[2] = i_reg_wdata & LINREG_MODE_WR_MASK;
        LINREG1_HIGH_PERF_SETTING_ADDR:
          st_next.lin_mode[3] = i_reg_wdata & LINREG_MODE_WR_MASK;
        LINREG1_STARTUP_ORDER_ADDR: st_next.lin_seq = i_reg_wdata;
        default: st_next.strap_done = st_reg.strap_done;
      endcase
    end
    // Strap capture once synchronised pins have settled; wins over a host write
    if (!st_reg.strap_done) begin
      st_next.strap_cnt = st_reg.strap_cnt + 2'h1;
      if (st_reg.strap_cnt == STRAP_SETTLE) begin
        st_next.strap_done = 1'b1;
        for (int i = 0; i < 4; i++) begin
          st_next.lin_mode[i][5:0] = vsel_s;
        end
      end
    end
    if (i_reg_rd) begin
      st_next.rdata = reg_read(st_reg, i_reg_addr);
    end
    // Short-circuit response
    unique case (st_reg.fsm)
      RCC_RUN: begin
        if (short_rise && cfg.hiccup_select) begin
          st_next.retry = 1'b1;
        end else if (short_rise) begin
          st_next.fsm = RCC_SHUTDOWN;
          st_next.timer = RESTART_LOAD;
        end
      end
      RCC_SHUTDOWN: begin
        if (st_reg.timer == '0) begin
          st_next.fsm = RCC_RUN;
          st_next.restart = 1'b1;
        end else begin
          st_next.timer = st_reg.timer - 1'b1;
        end
      end
    endcase
    // Enable: override wins over the mode enable, shutdown wins over both
    st_next.ch4_out = ch4_sel;
    if (cfg.register_override_select) begin
      st_next.ch4_out.enable = cfg.register_enable;
    end
    if (st_next.fsm == RCC_SHUTDOWN) begin
      st_next.ch4_out.enable = 1'b0;
    end
    st_next.lin_out = rcc_mode_t'(st_next.lin_mode[i_power_mode]);
    st_next.lin_out.forced_switching = 1'b0;
    if (st_next.fsm == RCC_SHUTDOWN) begin
      st_next.lin_out.enable = 1'b0;
    end
    // Discharge only on a switched-off channel, set means enabled
    st_next.drain = cfg.output_drain_enable & ~st_next.ch4_out.enable;
    st_next.irq_n = ~(fault_s & ~cfg.fault_irq_mask);
  end

  // State register; linear codes get their real value from the strap capture
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      st_reg <= '0;
      st_reg.ch4_hpm <= CH4_HIGH_POWER_SETTING_RST;
      st_reg.ch4_seq <= CH4_STARTUP_ORDER_RST;
      st_reg.ch4_cfg <= CH4_CHANNEL_CONFIG_RST;
      st_reg.lin_seq <= LINREG1_STARTUP_ORDER_RST;
      st_reg.irq_n <= 1'b1;
      st_reg.fsm <= RCC_RUN;
      for (int i = 0; i < 4; i++) begin
        st_reg.lin_mode[i] <= lin_rst(LINREG1_ENABLE_RST[i]);
      end
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign o_reg_rdata = st_reg.rdata;
  assign o_ch4_setting = st_reg.ch4_out;
  assign o_ch4_seq = ch4_seq_f;
  assign o_ch4_step_flags_ok = ~ch4_seq_f.step_participation | (ch4_ssd_s & ch4_pok_s);
  assign o_ch4_output_drain = st_reg.drain;
  assign o_ch4_phase_shift = cfg.phase_shift;
  assign o_ch4_voltage_slew_rate = cfg.voltage_slew_rate;
  assign o_ch4_hiccup_retry = st_reg.retry;
  assign o_linreg1_setting = st_reg.lin_out;
  assign o_linreg1_seq = lin_seq_f;
  assign o_linreg1_step_flags_ok = ~lin_seq_f.step_participation | (lin_ssd_s & lin_pok_s);
  assign o_all_channels_off = (st_reg.fsm == RCC_SHUTDOWN);
  assign o_restart_sequence = st_reg.restart;
  assign o_irq_out_n = st_reg.irq_n;

  // Checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);

  a_hpm_enable_follows: assert property (
    (i_power_mode == PMODE_HIGH_PERF && !cfg.register_override_select && !o_all_channels_off)
    ##1 ($stable(i_power_mode) && $stable(st_reg.ch4_hpm) && !o_all_channels_off)
    |-> o_ch4_setting.enable == st_reg.ch4_hpm[MODE_ENABLE_BIT])
    else $error("fourth buck enable differs from high-performance bit");
  a_forced_mode_kept: assert property (
    $stable(ch4_sel) |=> o_ch4_setting.forced_switching == $past(ch4_sel.forced_switching))
    else $error("switching mode not taken from selected mode register");
  a_hpm_voltage_code: assert property (
    i_power_mode == PMODE_HIGH_PERF |=> o_ch4_setting.voltage_code == $past(st_reg.ch4_hpm[5:0]))
    else $error("high-performance voltage code not applied");
  a_step_flags_ignored: assert property (
    !ch4_seq_f.step_participation |-> o_ch4_step_flags_ok)
    else $error("flags of non-participating channel not ignored");
  a_fault_irq_mask: assert property (
    cfg.fault_irq_mask [*2] |=> o_irq_out_n)
    else $error("masked fault pulled interrupt low");
  a_hiccup_local_retry: assert property (
    (st_reg.fsm == RCC_RUN && short_rise && cfg.hiccup_select)
    |=> o_ch4_hiccup_retry && !o_all_channels_off)
    else $error("hiccup short not handled locally");
  a_global_shutdown: assert property (
    (st_reg.fsm == RCC_RUN && short_rise && !cfg.hiccup_select)
    |=> o_all_channels_off && !o_ch4_setting.enable && !o_linreg1_setting.enable)
    else $error("short without hiccup did not shut all channels");
  a_restart_after_wait: assert property (
    (o_all_channels_off && st_reg.timer == '0) |=> o_restart_sequence && !o_all_channels_off)
    else $error("restart not issued when delay expired");
  a_drain_polarity: assert property (
    o_ch4_output_drain |-> ($past(cfg.output_drain_enable) && !o_ch4_setting.enable))
    else $error("discharge active with bit cleared or channel on");
  a_override_forces: assert property (
    (cfg.register_override_select && st_next.fsm == RCC_RUN)
    |=> o_ch4_setting.enable == $past(cfg.register_enable))
    else $error("register override did not force enable");
  a_linreg_mode_select: assert property (
    (st_next.fsm == RCC_RUN) |=> o_linreg1_setting.enable ==
      $past(st_next.lin_mode[i_power_mode][MODE_ENABLE_BIT]))
    else $error("linear enable not from active mode register");
  a_strap_load: assert property (
    (!st_reg.strap_done && st_reg.strap_cnt == STRAP_SETTLE)
    |=> st_reg.lin_mode[0][5:0] == $past(vsel_s) && st_reg.strap_done)
    else $error("strap code not loaded into linear regulator");

  // Writes landing, reserved bit, interrupt and shutdown outputs
  a_write_lands: assert property (
    (i_reg_wr && i_reg_addr == CH4_STARTUP_ORDER_ADDR)
    |=> o_ch4_seq == $past(i_reg_wdata))
    else $error("fourth buck sequencing write did not land");
  a_lin_seq_lands: assert property (
    (i_reg_wr && i_reg_addr == LINREG1_STARTUP_ORDER_ADDR)
    |=> o_linreg1_seq == $past(i_reg_wdata))
    else $error("linear sequencing write did not land");
  a_reserved_bit_low: assert property (
    (i_reg_rd && i_reg_addr >= LINREG1_ACTIVE_SETTING_ADDR
      && i_reg_addr <= LINREG1_HIGH_PERF_SETTING_ADDR)
    |=> !o_reg_rdata[MODE_FORCED_BIT])
    else $error("reserved linear mode bit reads back set");
  a_irq_unmasked: assert property (
    (fault_s && !cfg.fault_irq_mask) |=> !o_irq_out_n)
    else $error("unmasked fault did not pull interrupt low");
  a_shutdown_all_off: assert property (
    o_all_channels_off |-> !o_ch4_setting.enable && !o_linreg1_setting.enable)
    else $error("channel enabled during global shutdown");
  a_restart_one_pulse: assert property (
    o_restart_sequence |=> !o_restart_sequence)
    else $error("restart request longer than one cycle");
  a_override_mode_kept: assert property (
    cfg.register_override_select
    |=> o_ch4_setting.forced_switching == $past(ch4_sel.forced_switching))
    else $error("override changed the switching mode");

  // Main scenarios reached
  c_hiccup_retry: cover property (short_rise && cfg.hiccup_select);
  c_global_restart: cover property (o_restart_sequence);
  c_override_off: cover property (cfg.register_override_select && !o_ch4_setting.enable);
  c_irq_low: cover property (!o_irq_out_n);
  c_strap_loaded: cover property ($rose(st_reg.strap_done));

endmodule
`default_nettype wire

/* sim/rcc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rcc_host_model
  import rcc_pkg::*;
(
  // Clock
  input wire logic i_core_clk,
  // Register port towards the block
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_addr,
  output logic [7:0] o_reg_wdata,
  input wire logic [7:0] i_reg_rdata
);
  logic lin;

  // Idle bus starts quiet
  initial begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 8'h00;
    o_reg_wdata = 8'h00;
  end

  // Write; released lines show inverted leftovers so stale data never passes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    #1;
    lin = (a >= LINREG1_ACTIVE_SETTING_ADDR) && (a <= LINREG1_HIGH_PERF_SETTING_ADDR);
    o_reg_addr = a;
    o_reg_wdata = lin ? (d & LINREG_MODE_WR_MASK) : d;
    o_reg_wr = 1'b1;
    @(posedge i_core_clk);
    #1;
    o_reg_wr = 1'b0;
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
  endtask

  // Read; data is taken a cycle after the strobe edge, it holds till next read
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge i_core_clk);
    #1;
    o_reg_addr = a;
    o_reg_rd = 1'b1;
    @(posedge i_core_clk);
    #1;
    o_reg_rd = 1'b0;
    o_reg_addr = ~a;
    @(posedge i_core_clk);
    #1;
    q = i_reg_rdata;
  endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rcc_pkg::*;
  localparam int NRST = 20;
  logic i_core_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_reg_wr, i_reg_rd;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, q;
  logic [1:0] i_power_mode = 2'h3;
  rcc_mode_t i_ch4_lower_mode_setting = 8'h00;
  logic [5:0] pins = 6'h2A;
  logic fault_flag = 1'b0, sht = 1'b0;
  logic c_ssd = 1'b0, c_pok = 1'b0, l_ssd = 1'b0, l_pok = 1'b0;
  rcc_mode_t o_ch4_setting, o_linreg1_setting;
  rcc_seq_t o_ch4_seq, o_linreg1_seq;
  logic c_ok, l_ok, drain, phase, retry, all_off, restart, irq_n;
  logic [1:0] slew;
  int fail_count = 0, check_count = 0, cyc_n = 0, retry_cnt, off_cnt, rs_cnt;
  logic [7:0] ra [0:8] = '{8'h43, 8'h44, 8'h45, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h46};
  logic [7:0] re [0:8] = '{8'hFD, 8'h1C, 8'hA0, 8'hAA, 8'hAA, 8'h2A, 8'hAA, 8'h09, 8'h00};

  always #20 i_core_clk = ~i_core_clk;

  rcc_host_model host (.i_core_clk(i_core_clk), .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd),
    .o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata), .i_reg_rdata(o_reg_rdata));

  rcc_regs #(.P_RESTART_CYCLES(NRST)) DUT (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_power_mode(i_power_mode),
    .i_ch4_lower_mode_setting(i_ch4_lower_mode_setting), .i_linreg1_vsel_pins(pins),
    .i_ch4_fault_flag(fault_flag), .i_ch4_short(sht), .i_ch4_soft_start_done(c_ssd),
    .i_ch4_power_good(c_pok), .i_linreg1_soft_start_done(l_ssd),
    .i_linreg1_power_good(l_pok), .o_ch4_setting(o_ch4_setting), .o_ch4_seq(o_ch4_seq),
    .o_ch4_step_flags_ok(c_ok), .o_ch4_output_drain(drain), .o_ch4_phase_shift(phase),
    .o_ch4_voltage_slew_rate(slew), .o_ch4_hiccup_retry(retry),
    .o_linreg1_setting(o_linreg1_setting), .o_linreg1_seq(o_linreg1_seq),
    .o_linreg1_step_flags_ok(l_ok), .o_all_channels_off(all_off),
    .o_restart_sequence(restart), .o_irq_out_n(irq_n));

  // Pulse and level counters on the falling edge, where outputs have settled
  always @(negedge i_core_clk) begin
    cyc_n++;
    if (retry === 1'b1) retry_cnt++;
    if (all_off === 1'b1) off_cnt++;
    if (restart === 1'b1) rs_cnt++;
    if (cyc_n == 3000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  task automatic test_done();
    if (fail_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    cyc(3);
    i_reset = 1'b0;
    cyc(6);
    // Reset values, strap codes and an unmapped offset
    for (int i = 0; i < 9; i++) begin
      host.rd(ra[i], q);
      chk("reset", re[i], q);
    end
    // Sequencing fields pass straight through; the fourth buck one reads back
    host.wr(8'h44, 8'hED);
    host.wr(8'h54, 8'h5A);
    cyc(2);
    chk("seq4", 8'hED, o_ch4_seq);
    chk("seql", 8'h5A, o_linreg1_seq);
    host.rd(8'h44, q);
    chk("seq4_rd", 8'hED, q);
    // Linear setting follows the active power mode
    for (int i = 0; i < 4; i++) host.wr(8'h50 + 8'(i), 8'hC1 + 8'(i));
    for (int i = 0; i < 4; i++) begin
      i_power_mode = 2'(i);
      cyc(3);
      chk("linmode", (8'hC1 + 8'(i)) & 8'hBF, o_linreg1_setting);
    end
    // Fourth buck picks its own register only in high-performance mode
    i_ch4_lower_mode_setting = 8'hC5;
    i_power_mode = 2'h1;
    cyc(3);
    chk("ch4low", 8'hC5, o_ch4_setting);
    i_power_mode = 2'h3;
    host.wr(8'h43, 8'h3F);
    cyc(3);
    chk("ch4hpm", 8'h3F, o_ch4_setting);
    // Override forces enable, switching mode untouched
    host.wr(8'h45, 8'h03);
    cyc(2);
    chk("ovr_on", 8'hBF, o_ch4_setting);
    host.wr(8'h43, 8'hC1);
    host.wr(8'h45, 8'h01);
    cyc(2);
    chk("ovr_off", 8'h41, o_ch4_setting);
    host.wr(8'h45, 8'h02);
    cyc(2);
    chk("no_ovr", 8'hC1, o_ch4_setting);
    // Drain only with the bit set and the channel off
    chk("drain_en", 8'h00, drain);
    host.wr(8'h45, 8'h21);
    cyc(2);
    chk("drain_off", 8'h01, drain);
    host.wr(8'h45, 8'h01);
    cyc(2);
    chk("drain_clr", 8'h00, drain);
    // Phase and slew fields
    host.wr(8'h45, 8'h1C);
    cyc(2);
    chk("phase1", 8'h01, phase);
    chk("slew3", 8'h03, slew);
    host.wr(8'h45, 8'h08);
    cyc(2);
    chk("phase0", 8'h00, phase);
    chk("slew2", 8'h02, slew);
    // Interrupt line with the fault unmasked, then masked
    fault_flag = 1'b1;
    cyc(5);
    chk("irq", 8'h00, irq_n);
    host.wr(8'h45, 8'h88);
    cyc(5);
    chk("irq_mask", 8'h01, irq_n);
    fault_flag = 1'b0;
    // Participation on needs both flags, off ignores them
    chk("part_on", 8'h00, c_ok);
    c_ssd = 1'b1;
    cyc(4);
    chk("part_one", 8'h00, c_ok);
    host.wr(8'h44, 8'hE0);
    cyc(2);
    chk("part_off", 8'h01, c_ok);
    chk("lpart", 8'h00, l_ok);
    l_ssd = 1'b1;
    l_pok = 1'b1;
    cyc(4);
    chk("lflags", 8'h01, l_ok);
    // Hiccup: a single retry pulse, nothing shuts down
    host.wr(8'h45, 8'h40);
    retry_cnt = 0;
    off_cnt = 0;
    sht = 1'b1;
    cyc(10);
    sht = 1'b0;
    cyc(5);
    chk("retry", 8'h01, 8'(retry_cnt));
    chk("hic_off", 8'h00, 8'(off_cnt));
    // Global shutdown, timed restart
    host.wr(8'h45, 8'h02);
    off_cnt = 0;
    rs_cnt = 0;
    sht = 1'b1;
    cyc(8);
    chk("all_off", 8'h01, all_off);
    chk("ch4_en", 8'h00, 8'(o_ch4_setting.enable));
    chk("lin_en", 8'h00, 8'(o_linreg1_setting.enable));
    // A fresh short edge inside the shutdown must not stretch the wait
    sht = 1'b0;
    cyc(4);
    sht = 1'b1;
    cyc(4);
    sht = 1'b0;
    cyc(32);
    chk("off_len", 8'(NRST), 8'(off_cnt));
    chk("restart", 8'h01, 8'(rs_cnt));
    test_done();
  end
endmodule
`default_nettype wire
